/* File: core/lps_defines.vh */
// Constants for the loader panel sequencer
`ifndef LPS_DEFINES_VH
`define LPS_DEFINES_VH
`define LPS_CLK_HZ        100000000
`define LPS_TICK_MS       10
`define LPS_TICK_CYC      ((`LPS_CLK_HZ / 1000) * `LPS_TICK_MS)
`define LPS_ALL_ON_MS     1000
`define LPS_SELFTEST_MS   15000
`define LPS_DARK_MS       500
`define LPS_MECH_MS       20000
`define LPS_NSLOT         7
`define LPS_CMD_NONE      3'h0
`define LPS_CMD_SCAN      3'h1
`define LPS_CMD_GOSLOT    3'h2
`define LPS_CMD_PICK      3'h3
`define LPS_CMD_GODRIVE   3'h4
`define LPS_CMD_INSERT    3'h5
`define LPS_CMD_RETURN    3'h6
`define LPS_CMD_HOME      3'h7
`endif

/* File: core/lps_tick.v */
// Tick generator dividing the system clock
`timescale 1ns/10ps
module lps_tick #(
    parameter integer DIV = 1000000
) (
    input  wire ref_clk,
    input  wire sys_rst,
    output reg  tick_r
);
    reg [31:0] cnt_r;
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_r  <= 32'h0;
            tick_r <= 1'b0;
        end else if (cnt_r >= DIV - 1) begin
            cnt_r  <= 32'h0;
            tick_r <= 1'b1;
        end else begin
            cnt_r  <= cnt_r + 32'h1;
            tick_r <= 1'b0;
        end
    end
endmodule // lps_tick

/* File: core/lps_sync.v */
// Two-stage synchroniser for a bus of pin inputs
`timescale 1ns/10ps
module lps_sync #(
    parameter integer W = 1
) (
    input  wire         ref_clk,
    input  wire         sys_rst,
    input  wire [W-1:0] din,
    output reg  [W-1:0] dout
);
    reg [W-1:0] meta_r;
    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_r <= {W{1'b0}};
            dout   <= {W{1'b0}};
        end else begin
            meta_r <= din;
            dout   <= meta_r;
        end
    end
endmodule // lps_sync

/* File: core/lps_loader_panel_sequencer.v */
// Loader panel and mechanism sequencer
`timescale 1ns/10ps
`include "lps_defines.vh"
module lps_loader_panel_sequencer #(
    parameter integer TICK_CYC    = `LPS_TICK_CYC,
    parameter integer ALL_ON_TK   = `LPS_ALL_ON_MS / `LPS_TICK_MS,
    parameter integer SELFTEST_TK = `LPS_SELFTEST_MS / `LPS_TICK_MS,
    parameter integer DARK_TK     = `LPS_DARK_MS / `LPS_TICK_MS,
    parameter integer MECH_TK     = `LPS_MECH_MS / `LPS_TICK_MS
) (
    input  wire       ref_clk,
    input  wire       sys_rst,
    input  wire       drive_reset_req,
    input  wire       btn_select,
    input  wire       btn_load,
    input  wire       btn_eject,
    input  wire       key_panel_off,
    input  wire       mech_test_done,
    input  wire       mech_test_ok,
    input  wire       mech_done,
    input  wire       mech_fault,
    input  wire [6:0] scan_slots,
    input  wire       drive_loaded,
    input  wire       tape_start_marker,
    input  wire       receiver_closed,
    output reg        led_power_r,
    output reg        led_mag_fault_r,
    output reg        led_ldr_fault_r,
    output reg        led_select_r,
    output reg        led_load_r,
    output reg        led_eject_r,
    output reg  [6:0] led_slot_r,
    output reg        mech_test_start_r,
    output reg  [2:0] mech_cmd_r,
    output reg  [2:0] mech_slot_r,
    output reg        receiver_open_r
);
    localparam [3:0] S_PWR    = 4'h0,
                     S_TEST   = 4'h1,
                     S_WAITRS = 4'h2,
                     S_DARK   = 4'h3,
                     S_SCAN   = 4'h4,
                     S_READY  = 4'h5,
                     S_LOAD   = 4'h6,
                     S_BOT    = 4'h7,
                     S_LOADED = 4'h8,
                     S_UNLD   = 4'h9,
                     S_HOME   = 4'ha,
                     S_OPEN   = 4'hb,
                     S_FAIL   = 4'hc;

    wire       tick;
    wire [6:0] slots_s;
    wire [9:0] pins_s;
    wire       rst_req_s  = pins_s[0];
    wire       sel_s      = pins_s[1];
    wire       load_s     = pins_s[2];
    wire       ej_s       = pins_s[3];
    wire       keyoff_s   = pins_s[4];
    wire       tdone_s    = pins_s[5];
    wire       tok_s      = pins_s[6];
    wire       mdone_s    = pins_s[7];
    wire       mfault_s   = pins_s[8];
    wire       closed_s   = pins_s[9];
    wire       loaded_s;
    wire       bot_s;

    lps_tick #(.DIV(TICK_CYC)) u_tick (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .tick_r  (tick)
    );
    lps_sync #(.W(10)) u_sync_pins (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .din     ({receiver_closed, mech_fault, mech_done, mech_test_ok,
                   mech_test_done, key_panel_off, btn_eject, btn_load,
                   btn_select, drive_reset_req}),
        .dout    (pins_s)
    );
    lps_sync #(.W(9)) u_sync_mech (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .din     ({tape_start_marker, drive_loaded, scan_slots}),
        .dout    ({bot_s, loaded_s, slots_s})
    );

    // Next occupied slot above cur, wrapping to the lowest
    function [2:0] next_slot;
        input [6:0] occ;
        input [2:0] cur;
        integer i, idx;
        reg     found;
        begin
            found = 1'b0;
            next_slot = cur;
            for (i = 1; i <= `LPS_NSLOT; i = i + 1) begin
                idx = (cur + i) % `LPS_NSLOT;
                if (!found && occ[idx]) begin
                    found = 1'b1;
                    next_slot = idx[2:0];
                end
            end
        end
    endfunction

    reg [3:0]  state_r;
    reg [3:0]  state_nxt;
    reg [15:0] tmr_r;
    reg [1:0]  step_r;
    reg        pass2_r;
    reg [6:0]  occ_r;
    reg [2:0]  cur_r;
    reg        sel_q_r;
    reg        load_q_r;
    reg        ej_q_r;
    reg        rst_q_r;
    reg [1:0]  done_q_r;

    // Edge detect on buttons; done levels linger, so steps act on their rise
    wire sel_p  = sel_s & ~sel_q_r;
    wire load_p = load_s & ~load_q_r;
    wire ej_p   = ej_s & ~ej_q_r;
    wire rst_p  = rst_req_s & ~rst_q_r;
    // Presses count only while own light is lit
    wire sel_ok  = sel_p & led_select_r;
    wire load_ok = load_p & led_load_r;
    wire ej_ok   = ej_p & led_eject_r & ~keyoff_s;
    wire tmo     = (tmr_r >= MECH_TK[15:0]);

    always @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r           <= S_PWR;
            tmr_r             <= 16'h0;
            step_r            <= 2'h0;
            pass2_r           <= 1'b0;
            occ_r             <= 7'h0;
            cur_r             <= 3'h0;
            sel_q_r           <= 1'b0;
            load_q_r          <= 1'b0;
            ej_q_r            <= 1'b0;
            rst_q_r           <= 1'b0;
            done_q_r          <= 2'h0;
            led_power_r       <= 1'b1;
            led_mag_fault_r   <= 1'b0;
            led_ldr_fault_r   <= 1'b1;
            led_select_r      <= 1'b0;
            led_load_r        <= 1'b0;
            led_eject_r       <= 1'b0;
            led_slot_r        <= 7'h0;
            mech_test_start_r <= 1'b0;
            mech_cmd_r        <= `LPS_CMD_NONE;
            mech_slot_r       <= 3'h0;
            receiver_open_r   <= 1'b0;
        end else begin
            sel_q_r           <= sel_s;
            load_q_r          <= load_s;
            ej_q_r            <= ej_s;
            rst_q_r           <= rst_req_s;
            done_q_r          <= {tdone_s, mdone_s};
            mech_test_start_r <= 1'b0;
            led_power_r       <= 1'b1;
            if (tick) begin
                tmr_r <= tmr_r + 16'h1;
            end
            // Drive controller reset restarts the self-check anywhere
            if (rst_p) begin
                state_r         <= S_PWR;
                pass2_r         <= 1'b1;
                tmr_r           <= 16'h0;
                led_mag_fault_r <= 1'b0;
                led_ldr_fault_r <= 1'b1;
                led_select_r    <= 1'b0;
                led_load_r      <= 1'b0;
                led_eject_r     <= 1'b0;
                led_slot_r      <= 7'h0;
                mech_cmd_r      <= `LPS_CMD_NONE;
                receiver_open_r <= 1'b0;
            end else begin
                case (state_r)
                S_PWR: begin
                    if (tmr_r >= ALL_ON_TK[15:0]) begin
                        led_mag_fault_r   <= 1'b1;
                        led_select_r      <= 1'b1;
                        led_load_r        <= 1'b1;
                        led_eject_r       <= 1'b1;
                        led_slot_r        <= 7'h7f;
                        mech_test_start_r <= 1'b1;
                        tmr_r             <= 16'h0;
                        state_r           <= S_TEST;
                    end
                end
                S_TEST: begin
                    // Missing result by the deadline counts as failure
                    if ((tdone_s && !done_q_r[1]) || tmr_r >= SELFTEST_TK[15:0]) begin
                        tmr_r <= 16'h0;
                        if (tdone_s && !done_q_r[1] && tok_s) begin
                            led_mag_fault_r <= 1'b0;
                            led_ldr_fault_r <= 1'b0;
                            state_r <= pass2_r ? S_DARK : S_WAITRS;
                        end else begin
                            state_r <= S_FAIL;
                        end
                    end
                end
                S_WAITRS: state_r <= S_WAITRS; // Idle until drive controller reset
                S_DARK: begin
                    if (tmr_r >= DARK_TK[15:0]) begin
                        led_select_r <= 1'b0;
                        led_load_r   <= 1'b0;
                        led_eject_r  <= 1'b0;
                        led_slot_r   <= 7'h0;
                        mech_cmd_r   <= `LPS_CMD_SCAN;
                        tmr_r        <= 16'h0;
                        state_r      <= S_SCAN;
                    end
                end
                S_SCAN: begin
                    if (mdone_s && !done_q_r[0]) begin
                        mech_cmd_r <= `LPS_CMD_NONE;
                        occ_r      <= slots_s;
                        cur_r      <= 3'h0;
                        led_slot_r <= 7'h01;
                        led_select_r <= 1'b1;
                        led_load_r   <= 1'b1;
                        led_eject_r  <= 1'b1;
                        state_r    <= S_READY;
                    end else if (mfault_s || tmo) begin
                        state_r <= S_FAIL;
                    end
                end
                S_READY: begin
                    if (sel_ok) begin
                        cur_r      <= next_slot(occ_r, cur_r);
                        led_slot_r <= 7'h01 << next_slot(occ_r, cur_r);
                    end else if (load_ok) begin
                        led_select_r <= 1'b0;
                        led_load_r   <= 1'b0;
                        led_eject_r  <= 1'b0;
                        mech_slot_r  <= cur_r;
                        mech_cmd_r   <= `LPS_CMD_GOSLOT;
                        step_r       <= 2'h0;
                        tmr_r        <= 16'h0;
                        state_r      <= S_LOAD;
                    end else if (ej_ok) begin
                        led_select_r <= 1'b0;
                        led_load_r   <= 1'b0;
                        led_eject_r  <= 1'b0;
                        led_slot_r   <= 7'h0;
                        mech_cmd_r   <= `LPS_CMD_HOME;
                        step_r       <= 2'h0;
                        tmr_r        <= 16'h0;
                        state_r      <= S_HOME;
                    end
                end
                S_LOAD: begin
                    if (mfault_s || tmo) begin
                        state_r <= S_FAIL;
                    end else if (mdone_s && !done_q_r[0]) begin
                        tmr_r  <= 16'h0;
                        step_r <= step_r + 2'h1;
                        case (step_r)
                        2'h0: mech_cmd_r <= `LPS_CMD_PICK;
                        2'h1: mech_cmd_r <= `LPS_CMD_GODRIVE;
                        2'h2: mech_cmd_r <= `LPS_CMD_INSERT;
                        default: begin
                            mech_cmd_r <= `LPS_CMD_NONE;
                            state_r    <= S_BOT;
                        end
                        endcase
                    end
                end
                S_BOT: begin
                    if (bot_s && loaded_s) begin
                        led_load_r   <= 1'b1;
                        led_eject_r  <= 1'b1;
                        led_select_r <= 1'b0;
                        state_r      <= S_LOADED;
                    end
                end
                S_LOADED: begin
                    if (load_ok || ej_ok) begin
                        led_select_r <= 1'b0;
                        led_load_r   <= 1'b0;
                        led_eject_r  <= 1'b0;
                        mech_slot_r  <= cur_r;
                        mech_cmd_r   <= `LPS_CMD_RETURN;
                        step_r       <= {1'b0, ej_ok};
                        tmr_r        <= 16'h0;
                        state_r      <= S_UNLD;
                    end
                end
                S_UNLD: begin
                    if (mfault_s || tmo) begin
                        state_r <= S_FAIL;
                    end else if (mdone_s && !done_q_r[0]) begin
                        mech_cmd_r <= `LPS_CMD_NONE;
                        if (step_r[0]) begin
                            led_slot_r      <= 7'h0;
                            receiver_open_r <= 1'b1;
                            state_r         <= S_OPEN;
                        end else begin
                            led_select_r <= 1'b1;
                            led_load_r   <= 1'b1;
                            led_eject_r  <= 1'b1;
                            state_r      <= S_READY;
                        end
                    end
                end
                S_HOME: begin
                    if (mfault_s || tmo) begin
                        state_r <= S_FAIL;
                    end else if (mdone_s && !done_q_r[0]) begin
                        mech_cmd_r      <= `LPS_CMD_NONE;
                        receiver_open_r <= 1'b1;
                        state_r         <= S_OPEN;
                    end
                end
                S_OPEN: begin
                    // Wait for receiver to leave then close again
                    if (!closed_s) begin
                        receiver_open_r <= 1'b0;
                        step_r          <= 2'h3;
                    end else if (step_r == 2'h3) begin
                        mech_cmd_r <= `LPS_CMD_SCAN;
                        tmr_r      <= 16'h0;
                        state_r    <= S_SCAN;
                    end
                end
                S_FAIL: begin
                    led_mag_fault_r <= 1'b1;
                    led_ldr_fault_r <= 1'b1;
                    mech_cmd_r      <= `LPS_CMD_NONE;
                    led_load_r      <= 1'b1;
                    if (load_ok) begin
                        pass2_r           <= 1'b1;
                        led_mag_fault_r   <= 1'b0;
                        led_load_r        <= 1'b0;
                        tmr_r             <= 16'h0;
                        state_r           <= S_PWR;
                    end
                end
                default: state_r <= S_PWR;
                endcase
            end
        end
    end
endmodule // lps_loader_panel_sequencer

/* File: bench/lps_seq_properties.sv */
// Port checks for the loader panel sequencer
`timescale 1ns/10ps
`include "lps_defines.vh"
module lps_seq_chk (
    input wire       ref_clk,
    input wire       sys_rst,
    input wire       btn_select,
    input wire       btn_eject,
    input wire       key_panel_off,
    input wire       led_mag_fault_r,
    input wire       led_ldr_fault_r,
    input wire       led_select_r,
    input wire       led_load_r,
    input wire       led_eject_r,
    input wire [6:0] led_slot_r,
    input wire       mech_test_start_r,
    input wire [2:0] mech_cmd_r,
    input wire       receiver_open_r
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    sequence s_insert_end;
        (mech_cmd_r == `LPS_CMD_INSERT) ##1 (mech_cmd_r != `LPS_CMD_INSERT);
    endsequence
    // Key held long enough to pass the pin synchroniser first
    sequence s_eject_locked;
        key_panel_off[*4] ##0 $rose(btn_eject);
    endsequence
    sequence s_select_dark;
        (!led_select_r)[*4] ##0 $rose(btn_select);
    endsequence
    AST_RESET_LIGHTS: assert property ($fell(sys_rst) |-> led_ldr_fault_r && !led_mag_fault_r
        && !led_select_r && !led_load_r && !led_eject_r) else $error("reset lights wrong");
    AST_ALL_ON: assert property (mech_test_start_r |-> ##[0:2] (led_select_r && led_load_r
        && led_eject_r && led_mag_fault_r && led_ldr_fault_r)) else $error("lights not all on");
    AST_FAULTS_TOGETHER: assert property ($fell(led_ldr_fault_r) |-> !led_mag_fault_r)
        else $error("fault lights split");
    AST_SCAN_DARK: assert property ((mech_cmd_r == `LPS_CMD_SCAN) |-> !led_load_r
        && !led_eject_r && !led_select_r) else $error("button lit during scan");
    AST_LOAD_DARK: assert property ((mech_cmd_r inside {[`LPS_CMD_GOSLOT:`LPS_CMD_INSERT]})
        |-> !(led_select_r || led_load_r || led_eject_r)) else $error("light during load");
    AST_LOADED_SELECT: assert property (s_insert_end |-> !led_select_r)
        else $error("select lit after insert");
    AST_EJECT_LOCKED: assert property (s_eject_locked |=> $stable(receiver_open_r)[*6])
        else $error("eject acted with panel off");
    AST_DARK_PRESS: assert property (s_select_dark |=> $stable(led_slot_r)[*6])
        else $error("dark select acted");
    AST_OPEN_DARK: assert property ($rose(receiver_open_r) |-> !led_select_r && !led_load_r
        && !led_eject_r) else $error("lights lit at open");
endmodule // lps_seq_chk
bind lps_loader_panel_sequencer lps_seq_chk i_chk (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .btn_select(btn_select), .btn_eject(btn_eject),
    .key_panel_off(key_panel_off), .led_mag_fault_r(led_mag_fault_r),
    .led_ldr_fault_r(led_ldr_fault_r), .led_select_r(led_select_r), .led_load_r(led_load_r),
    .led_eject_r(led_eject_r), .led_slot_r(led_slot_r), .mech_test_start_r(mech_test_start_r),
    .mech_cmd_r(mech_cmd_r), .receiver_open_r(receiver_open_r)
);

/* File: bench/lps_mech_model.sv */
// Loader mechanism and receiver model facing the sequencer
`timescale 1ns/10ps
`include "lps_defines.vh"
module lps_mech_model (
    input  wire       ref_clk,
    input  wire       slow,
    input  wire       test_ok,
    input  wire       mech_test_start_r,
    input  wire [2:0] mech_cmd_r,
    input  wire       receiver_open_r,
    output reg        mech_test_done = 1'b0,
    output reg        mech_test_ok = 1'b0,
    output reg        mech_done = 1'b0,
    output reg        drive_loaded = 1'b0,
    output reg        tape_start_marker = 1'b0,
    output reg        receiver_closed = 1'b1
);
    reg [2:0] cmd_seen_r = 3'h0;
    reg [7:0] step_cnt_r = 8'h00;
    reg [7:0] test_cnt_r = 8'h00;
    reg [7:0] rcv_cnt_r = 8'h00;
    reg       open_seen_r = 1'b0;
    always @(posedge ref_clk) begin
        cmd_seen_r  <= mech_cmd_r;
        open_seen_r <= receiver_open_r;
        // Done drops on every new command so stale completion never leaks
        if (mech_cmd_r != cmd_seen_r) begin
            mech_done  <= 1'b0;
            step_cnt_r <= slow ? 8'h0c : 8'h05;
        end else if (step_cnt_r != 8'h00) begin
            step_cnt_r <= step_cnt_r - 8'h01;
        end else if (mech_cmd_r != `LPS_CMD_NONE && !mech_done) begin
            mech_done <= 1'b1;
            if (mech_cmd_r == `LPS_CMD_INSERT || mech_cmd_r == `LPS_CMD_RETURN) begin
                drive_loaded      <= (mech_cmd_r == `LPS_CMD_INSERT);
                tape_start_marker <= (mech_cmd_r == `LPS_CMD_INSERT);
            end
        end
        if (mech_test_start_r) begin
            mech_test_done <= 1'b0;
            mech_test_ok   <= 1'b0;
            test_cnt_r     <= slow ? 8'h28 : 8'h14;
        end else if (test_cnt_r != 8'h00) begin
            test_cnt_r     <= test_cnt_r - 8'h01;
            mech_test_done <= (test_cnt_r == 8'h01);
            mech_test_ok   <= (test_cnt_r == 8'h01) && test_ok;
        end
        // Operator pulls the receiver open, then pushes it shut later
        if (rcv_cnt_r != 8'h00) begin
            rcv_cnt_r       <= rcv_cnt_r - 8'h01;
            receiver_closed <= (rcv_cnt_r == 8'h01) || (rcv_cnt_r > 8'h32);
        end else if (receiver_open_r && !open_seen_r) begin
            rcv_cnt_r <= 8'h3c;
        end
    end
endmodule // lps_mech_model

/* File: bench/lps_loader_panel_sequencer_bench.sv */
// Self-checking bench for the loader panel sequencer
`timescale 1ns/10ps
`include "lps_defines.vh"
module lps_loader_panel_sequencer_bench;
    reg         ref_clk, sys_rst, drive_reset_req, key_panel_off, slow, mfault, test_ok;
    reg         btn_select, btn_load, btn_eject;
    reg  [6:0]  scan_slots;
    wire        led_power_r, led_mag_fault_r, led_ldr_fault_r, led_select_r, led_load_r;
    wire        led_eject_r, receiver_open_r, mech_test_start_r, mech_test_done;
    wire        mech_test_ok, mech_done, drive_loaded, tape_start_marker, receiver_closed;
    wire [6:0]  led_slot_r;
    wire [2:0]  mech_cmd_r, mech_slot_r;
    wire [6:0]  lights = {led_power_r, led_mag_fault_r, led_ldr_fault_r, led_select_r,
                          led_load_r, led_eject_r, receiver_open_r};
    reg  [2:0]  last_cmd = 3'h0;
    reg  [2:0]  cmd_q[$];
    reg  [31:0] seed;
    integer     mismatches, n_checks, cur, i;
    integer     cycles = 0;
    lps_loader_panel_sequencer #(.TICK_CYC(10), .ALL_ON_TK(4), .SELFTEST_TK(60), .DARK_TK(3),
        .MECH_TK(100)) i_dut (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .drive_reset_req(drive_reset_req),
        .btn_select(btn_select), .btn_load(btn_load), .btn_eject(btn_eject),
        .key_panel_off(key_panel_off), .mech_test_done(mech_test_done),
        .mech_test_ok(mech_test_ok), .mech_done(mech_done), .mech_fault(mfault),
        .scan_slots(scan_slots), .drive_loaded(drive_loaded), .receiver_closed(receiver_closed),
        .tape_start_marker(tape_start_marker), .led_power_r(led_power_r),
        .led_mag_fault_r(led_mag_fault_r), .led_ldr_fault_r(led_ldr_fault_r),
        .led_select_r(led_select_r), .led_load_r(led_load_r), .led_eject_r(led_eject_r),
        .led_slot_r(led_slot_r), .mech_test_start_r(mech_test_start_r), .mech_cmd_r(mech_cmd_r),
        .mech_slot_r(mech_slot_r), .receiver_open_r(receiver_open_r));
    lps_mech_model i_mech (.ref_clk(ref_clk), .slow(slow), .test_ok(test_ok),
        .mech_test_start_r(mech_test_start_r), .mech_cmd_r(mech_cmd_r),
        .receiver_open_r(receiver_open_r), .mech_test_done(mech_test_done),
        .mech_test_ok(mech_test_ok), .mech_done(mech_done), .drive_loaded(drive_loaded),
        .tape_start_marker(tape_start_marker), .receiver_closed(receiver_closed));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Nearest occupied slot above c, wrapping round to the lowest
    function integer next_slot(input [6:0] occ, input integer c);
        integer k;
        begin
            next_slot = c;
            for (k = 6; k >= 1; k = k - 1)
                if (occ[(c + k) % 7]) next_slot = (c + k) % 7;
        end
    endfunction
    function [14:0] cmds_seen();
        integer k;
        begin
            cmds_seen = 15'h0000;
            cmds_seen[14:12] = 3'(cmd_q.size());
            for (k = 0; k < cmd_q.size() && k < 4; k = k + 1)
                cmds_seen[3*k +: 3] = cmd_q[k];
        end
    endfunction
    function hit(input integer c);
        case (c)
            0: hit = led_select_r && led_mag_fault_r;
            1: hit = !led_mag_fault_r && !led_ldr_fault_r;
            2: hit = led_select_r && !led_mag_fault_r;
            3: hit = led_load_r;
            4: hit = receiver_open_r;
            default: hit = !led_select_r;
        endcase
    endfunction
    task conclude;
        if (mismatches == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task check(input [14:0] got, input [14:0] exp);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("unexpected %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Hold the button past the synchroniser, then let the answer settle
    task press(input integer b);
        @(posedge ref_clk);
        {btn_select, btn_load, btn_eject} <= {b == 0, b == 1, b == 2};
        repeat (4) @(posedge ref_clk);
        {btn_select, btn_load, btn_eject} <= 3'b000;
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
    task await(input integer c);
        integer k;
        k = 0;
        while (!hit(c) && k < 3000) begin
            @(posedge ref_clk);
            k = k + 1;
        end
        if (k == 3000) check(15'h0000, 15'h0001);
        @(negedge ref_clk);
    endtask
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        last_cmd <= mech_cmd_r;
        if (mech_cmd_r !== last_cmd && mech_cmd_r !== `LPS_CMD_NONE) cmd_q.push_back(mech_cmd_r);
        if (cycles == 20000) begin
            mismatches = mismatches + 1;
            $display("unexpected %0t: run too long", $time);
            conclude;
        end
    end
    initial begin
        mismatches = 0;
        n_checks = 0;
        cur = 0;
        {sys_rst, drive_reset_req, key_panel_off, slow, mfault, test_ok} = 6'b100001;
        {btn_select, btn_load, btn_eject} = 3'b000;
        seed = lfsr(32'heb93151f);
        scan_slots = seed[6:0] | 7'h09;
        repeat (8) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(negedge ref_clk);
        check({8'h00, lights}, 15'h0050);
        await(0);
        check({8'h00, lights}, 15'h007e);
        await(1);
        check({8'h00, lights}, 15'h004e);
        @(posedge ref_clk) drive_reset_req <= 1'b1;
        repeat (4) @(posedge ref_clk);
        drive_reset_req <= 1'b0;
        repeat (4) @(negedge ref_clk);
        check({8'h00, lights}, 15'h0050);
        await(1);
        await(5);
        check({8'h00, lights}, 15'h0040);
        await(2);
        check({8'h00, lights}, 15'h004e);
        check({8'h00, led_slot_r}, 15'h0001);
        check(cmds_seen(), {3'd1, 9'h000, `LPS_CMD_SCAN});
        for (i = 0; i < 8; i = i + 1) begin
            seed = lfsr(seed);
            slow <= seed[0];
            press(0);
            cur = next_slot(scan_slots, cur);
            check({8'h00, led_slot_r}, 15'h0001 << cur);
            check({8'h00, lights}, 15'h004e);
        end
        @(posedge ref_clk) key_panel_off <= 1'b1;
        repeat (4) @(posedge ref_clk);
        press(2);
        check({8'h00, lights}, 15'h004e);
        @(posedge ref_clk) key_panel_off <= 1'b0;
        cmd_q.delete();
        press(1);
        check({8'h00, lights}, 15'h0040);
        check({12'h000, mech_slot_r}, cur[14:0]);
        await(3);
        check({8'h00, lights}, 15'h0046);
        check(cmds_seen(), {3'd4, `LPS_CMD_INSERT, `LPS_CMD_GODRIVE, `LPS_CMD_PICK,
            `LPS_CMD_GOSLOT});
        press(0);
        check({8'h00, led_slot_r}, 15'h0001 << cur);
        cmd_q.delete();
        press(1);
        await(2);
        check(cmds_seen(), {3'd1, 9'h000, `LPS_CMD_RETURN});
        check({8'h00, led_slot_r}, 15'h0001 << cur);
        cmd_q.delete();
        press(2);
        check({8'h00, lights & 7'h7e}, 15'h0040);
        await(4);
        check(cmds_seen(), {3'd1, 9'h000, `LPS_CMD_HOME});
        cmd_q.delete();
        await(2);
        check(cmds_seen(), {3'd1, 9'h000, `LPS_CMD_SCAN});
        check({8'h00, led_slot_r}, 15'h0001);
        press(1);
        await(3);
        cmd_q.delete();
        press(2);
        check({8'h00, lights & 7'h7e}, 15'h0040);
        await(4);
        check({14'h0000, cmd_q.size() > 0 && cmd_q[0] == `LPS_CMD_RETURN}, 15'h0001);
        await(2);
        @(posedge ref_clk) mfault <= 1'b1;
        press(2);
        check({8'h00, lights}, 15'h0074);
        @(posedge ref_clk) mfault <= 1'b0;
        press(1);
        await(2);
        conclude;
    end
endmodule // lps_loader_panel_sequencer_bench
